// ---- hdl/nov_stage.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "nov_params.svh"
module nov_stage #(
  parameter int TICK_CYC = `NOV_CLK_HZ / 1000000 * `NOV_TICK_US,
  parameter int NGRP = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic signed [15:0] phaseOneRe,
  input wire logic signed [15:0] phaseOneIm,
  input wire logic signed [15:0] phaseTwoRe,
  input wire logic signed [15:0] phaseTwoIm,
  input wire logic signed [15:0] phaseThreeRe,
  input wire logic signed [15:0] phaseThreeIm,
  input wire logic [15:0] auxResidualA,
  input wire logic [15:0] auxResidualB,
  input wire logic blockIn,
  input wire logic forceGlobalEn,
  input wire logic [4:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic startOut,
  output logic tripOut,
  output logic blockedOut,
  output nov_pkg::nov_src_type measNow,
  output logic irq
);
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam logic [18:0] MAXT = 19'(`NOV_MAX_TIME_MS / `NOV_STEP_MS);
  localparam logic [4:0] DIALX = 5'(`NOV_DIAL_STEP_MS / `NOV_STEP_MS);
  localparam logic [24:0] QONE = 25'(1 << `NOV_Q);

  // 5 ms processing tick
  logic [TW-1:0] tickCnt_r;
  wire tickWrap = (tickCnt_r == TW'(TICK_CYC - 1));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_r <= '0;
    end else begin
      tickCnt_r <= tickWrap ? '0 : tickCnt_r + 1'b1;
    end
  end

  // register file: control bits are held outside the groups
  logic [`NOV_CTL_W-1:0] ctrl_r;
  logic [`NOV_EV_W-1:0] ist_r;
  logic [`NOV_EV_W-1:0] imsk_r;
  logic [14:0] relDly_r;
  logic [15:0] thr_r [NGRP];
  logic [18:0] dly_r [NGRP];
  logic [15:0] dial_r [NGRP];
  logic [15:0] mult_r [NGRP];
  wire wrCtrl = regWr && (regAddr == `NOV_REG_CTRL);
  wire wrIst = regWr && (regAddr == `NOV_REG_IST);
  wire wrImsk = regWr && (regAddr == `NOV_REG_IMSK);
  wire wrRel = regWr && (regAddr == `NOV_REG_RELDLY);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `NOV_CTL_RST;
      imsk_r <= '0;
      relDly_r <= `NOV_RELDLY_RST;
    end else begin
      if (wrCtrl) ctrl_r <= regWdata[`NOV_CTL_W-1:0];
      if (wrImsk) imsk_r <= regWdata[`NOV_EV_W-1:0];
      if (wrRel) relDly_r <= regWdata[14:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NGRP; g++) begin : gGrp
      wire [4:0] base = 5'(`NOV_REG_GRP0 + g * `NOV_GRP_STRIDE);
      wire wrThr = regWr && (regAddr == base + `NOV_GF_THR);
      wire wrDly = regWr && (regAddr == base + `NOV_GF_DLY);
      wire wrDial = regWr && (regAddr == base + `NOV_GF_DIAL);
      wire wrMult = regWr && (regAddr == base + `NOV_GF_MULT);
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          thr_r[g] <= `NOV_THR_RST;
          dly_r[g] <= `NOV_DLY_RST;
          dial_r[g] <= `NOV_DIAL_RST;
          mult_r[g] <= `NOV_MULT_RST;
        end else begin
          if (wrThr) thr_r[g] <= regWdata[15:0];
          if (wrDly) dly_r[g] <= regWdata[18:0];
          if (wrDial) dial_r[g] <= regWdata[15:0];
          if (wrMult) mult_r[g] <= regWdata[15:0];
        end
      end
    end
  endgenerate

  wire grpSel = ctrl_r[`NOV_CTL_GRP];
  wire [15:0] thrRaw = thr_r[grpSel];
  wire [15:0] thrAct = (thrRaw == 16'h0000) ? 16'h0001 : thrRaw;
  wire [18:0] dlyAct = dly_r[grpSel];
  wire [15:0] dialAct = dial_r[grpSel];
  wire [15:0] multAct = mult_r[grpSel];
  wire relEn = ctrl_r[`NOV_CTL_RELEN];

  wire signed [17:0] sumRe = 18'(phaseOneRe) + 18'(phaseTwoRe) + 18'(phaseThreeRe);
  wire signed [17:0] sumIm = 18'(phaseOneIm) + 18'(phaseTwoIm) + 18'(phaseThreeIm);
  wire [17:0] absRe = sumRe[17] ? 18'(-sumRe) : 18'(sumRe);
  wire [17:0] absIm = sumIm[17] ? 18'(-sumIm) : 18'(sumIm);
  wire [17:0] mx = (absRe > absIm) ? absRe : absIm;
  wire [17:0] mn = (absRe > absIm) ? absIm : absRe;
  // magnitude by max plus 3/8 min, within a few percent, avoids a root
  wire [18:0] sumMag = 19'(mx) + 19'(mn >> 2) + 19'(mn >> 3);
  wire [34:0] thirdProd = 35'(sumMag) * 35'(`NOV_THIRD_MUL);
  // units of 0.01 % so a full fault reads 10000
  wire [18:0] calcRes = thirdProd[`NOV_THIRD_SH +: 19];
  wire [15:0] calcSat = (calcRes[18:16] != 3'h0) ? 16'hffff : calcRes[15:0];

  wire [1:0] selField = ctrl_r[`NOV_CTL_SEL];
  wire lnConn = ctrl_r[`NOV_CTL_LN];
  // aux only when channel set to residual mode
  wire auxAOk = ctrl_r[`NOV_CTL_AUXA];
  wire auxBOk = ctrl_r[`NOV_CTL_AUXB];
  wire nov_pkg::nov_src_type dfltSrc = lnConn ? nov_pkg::NOV_SRC_CALC :
    auxAOk ? nov_pkg::NOV_SRC_AUXA : auxBOk ? nov_pkg::NOV_SRC_AUXB : nov_pkg::NOV_SRC_NONE;
  wire nov_pkg::nov_src_type srcSel =
    (selField == 2'h1 && lnConn) ? nov_pkg::NOV_SRC_CALC :
    (selField == 2'h2 && auxAOk) ? nov_pkg::NOV_SRC_AUXA :
    (selField == 2'h3 && auxBOk) ? nov_pkg::NOV_SRC_AUXB : dfltSrc;
  wire [15:0] measSel = (srcSel == nov_pkg::NOV_SRC_CALC) ? calcSat :
    (srcSel == nov_pkg::NOV_SRC_AUXA) ? auxResidualA :
    (srcSel == nov_pkg::NOV_SRC_AUXB) ? auxResidualB : 16'h0000;

  // per-tick sequencer
  nov_pkg::nov_seq_type seq_r;
  logic [15:0] meas_r;
  nov_pkg::nov_src_type src_r;
  logic blkS_r;
  logic [23:0] r8_r;
  logic [23:0] pow_r;
  logic [6:0] powCnt_r;
  logic [18:0] inverse_time_mode_r;
  wire divDone0;
  wire divDone1;
  wire [31:0] quo0;
  wire [31:0] quo1;
  wire startR0 = (seq_r == nov_pkg::NOV_SQ_IDLE) && tickWrap;
  wire [6:0] aInt = (multAct < 16'd200) ? 7'h01 : 7'(multAct / 16'd100);
  wire [47:0] powProd = 48'(pow_r) * 48'(r8_r);
  wire [39:0] powSh = powProd[`NOV_Q +: 40];
  wire [23:0] powNxt = (powSh[39:24] != 16'h0) ? `NOV_SAT24 : powSh[23:0];
  wire powDone = (seq_r == nov_pkg::NOV_SQ_POW) && (powCnt_r == 7'h00);
  wire powAbove = (25'(pow_r) > QONE);
  wire startR1 = powDone && powAbove;
  wire [31:0] num1 = 32'(32'(dialAct) * 32'(DIALX)) << `NOV_Q;
  wire [31:0] den1 = 32'(25'(pow_r) - QONE);

  nov_divider #(.W(32)) uRatio (
    .clk(clk),
    .rst_n(rst_n),
    .startDiv(startR0),
    .numIn(32'(measSel) << `NOV_Q),
    .denIn(32'(thrAct)),
    .doneOut(divDone0),
    .quoOut(quo0)
  );
  nov_divider #(.W(32)) uTime (
    .clk(clk),
    .rst_n(rst_n),
    .startDiv(startR1),
    .numIn(num1),
    .denIn(den1),
    .doneOut(divDone1),
    .quoOut(quo1)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_r <= nov_pkg::NOV_SQ_IDLE;
      meas_r <= '0;
      src_r <= nov_pkg::NOV_SRC_NONE;
      blkS_r <= 1'b0;
      r8_r <= '0;
      pow_r <= '0;
      powCnt_r <= '0;
      inverse_time_mode_r <= '0;
    end else begin
      unique case (seq_r)
        nov_pkg::NOV_SQ_IDLE: if (tickWrap) begin
          meas_r <= measSel;
          src_r <= srcSel;
          blkS_r <= blockIn;
          seq_r <= nov_pkg::NOV_SQ_RDIV;
        end
        nov_pkg::NOV_SQ_RDIV: if (divDone0) begin
          r8_r <= (quo0[31:24] != 8'h0) ? `NOV_SAT24 : quo0[23:0];
          pow_r <= (quo0[31:24] != 8'h0) ? `NOV_SAT24 : quo0[23:0];
          powCnt_r <= aInt - 7'h01;
          seq_r <= nov_pkg::NOV_SQ_POW;
        end
        nov_pkg::NOV_SQ_POW: begin
          if (powCnt_r != 7'h00) begin
            pow_r <= powNxt;
            powCnt_r <= powCnt_r - 7'h01;
          end else if (powAbove) begin
            seq_r <= nov_pkg::NOV_SQ_TDIV;
          end else begin
            inverse_time_mode_r <= MAXT;
            seq_r <= nov_pkg::NOV_SQ_EVAL;
          end
        end
        // dial over ratio power minus one
        nov_pkg::NOV_SQ_TDIV: if (divDone1) begin
          inverse_time_mode_r <= (quo1 > 32'(MAXT)) ? MAXT : quo1[18:0];
          seq_r <= nov_pkg::NOV_SQ_EVAL;
        end
        nov_pkg::NOV_SQ_EVAL: seq_r <= nov_pkg::NOV_SQ_IDLE;
        default: seq_r <= nov_pkg::NOV_SQ_IDLE;
      endcase
    end
  end

  // protection state, updated in the eval cycle only
  wire evalNow = (seq_r == nov_pkg::NOV_SQ_EVAL);
  logic pick_r;
  logic start_r;
  logic trip_r;
  logic blk_r;
  logic [18:0] opCnt_r;
  logic [14:0] relCnt_r;
  logic [15:0] ratio_r;
  logic [18:0] expT_r;
  wire [18:0] expT = expT_r;
  logic selIdmt_r;
  wire dlyTypeIdmt = (multAct != 16'h0000) && selIdmt_r;
  wire [18:0] expNow = dlyTypeIdmt ? inverse_time_mode_r : dlyAct;
  wire pickOn = (meas_r > thrAct);
  wire pickOff = (24'(meas_r) * 24'(`NOV_PCT_SCALE)) < (24'(thrAct) * 24'(`NOV_HYST_PCT));
  wire pickNxt = (src_r != nov_pkg::NOV_SRC_NONE) && (pick_r ? !pickOff : pickOn);
  wire [18:0] opNew = start_r ? opCnt_r + 19'h1 : 19'h0;
  wire [31:0] ratioW = 32'(r8_r) * 32'(`NOV_PCT_SCALE);
  wire [23:0] ratioQ = ratioW[`NOV_Q +: 24];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pick_r <= 1'b0;
      start_r <= 1'b0;
      trip_r <= 1'b0;
      blk_r <= 1'b0;
      opCnt_r <= '0;
      relCnt_r <= '0;
      ratio_r <= '0;
      expT_r <= '0;
      selIdmt_r <= 1'b0;
    end else if (evalNow) begin
      selIdmt_r <= ctrl_r[`NOV_CTL_W-1];
      pick_r <= pickNxt;
      ratio_r <= (ratioQ[23:16] != 8'h0) ? 16'hffff : ratioQ[15:0];
      expT_r <= expNow;
      if (pickNxt && blkS_r) begin
        blk_r <= 1'b1;
        start_r <= 1'b0;
        trip_r <= 1'b0;
        opCnt_r <= '0;
        relCnt_r <= '0;
      end else if (pickNxt) begin
        blk_r <= 1'b0;
        start_r <= 1'b1;
        opCnt_r <= opNew;
        relCnt_r <= '0;
        trip_r <= (opNew >= expNow);
      end else begin
        blk_r <= 1'b0;
        trip_r <= 1'b0;
        if (start_r && relEn && relCnt_r == 15'h0 && pick_r) begin
          relCnt_r <= relDly_r;
          start_r <= (relDly_r != 15'h0);
        end else if (relCnt_r > 15'h1) begin
          relCnt_r <= relCnt_r - 15'h1;
        end else begin
          relCnt_r <= '0;
          start_r <= 1'b0;
          opCnt_r <= '0;
        end
      end
    end
  end

  wire signed [19:0] remain = start_r ? 20'(expT) - 20'(opCnt_r) : 20'sh00000;

  wire nov_pkg::nov_force_type frc = nov_pkg::nov_force_type'(ctrl_r[`NOV_CTL_FORCE]);
  wire frcAct = forceGlobalEn && (frc != nov_pkg::NOV_FRC_NORMAL);
  wire stNow = frcAct ? (frc == nov_pkg::NOV_FRC_START) : start_r;
  wire trNow = frcAct ? (frc == nov_pkg::NOV_FRC_TRIP) : trip_r;
  wire bkNow = frcAct ? (frc == nov_pkg::NOV_FRC_BLOCKED) : blk_r;
  logic stQ_r;
  logic trQ_r;
  logic bkQ_r;
  wire [`NOV_EV_W-1:0] evRise = {bkNow & ~bkQ_r, trNow & ~trQ_r, stNow & ~stQ_r};
  // set beats a write-one clear in the same cycle
  wire [`NOV_EV_W-1:0] istNxt =
    (ist_r & ~(wrIst ? regWdata[`NOV_EV_W-1:0] : '0)) | evRise;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stQ_r <= 1'b0;
      trQ_r <= 1'b0;
      bkQ_r <= 1'b0;
      ist_r <= '0;
    end else begin
      stQ_r <= stNow;
      trQ_r <= trNow;
      bkQ_r <= bkNow;
      ist_r <= istNxt;
    end
  end
  assign startOut = stQ_r;
  assign tripOut = trQ_r;
  assign blockedOut = bkQ_r;
  assign measNow = src_r;
  assign irq = |(ist_r & imsk_r);

  // read mux
  wire [4:0] gOff = regAddr - `NOV_REG_GRP0;
  wire gHit = (regAddr >= `NOV_REG_GRP0) &&
    (gOff < 5'(NGRP * `NOV_GRP_STRIDE));
  wire gIdx = gOff[2];
  wire [31:0] grpRd = (gOff[1:0] == 2'h0) ? 32'(thr_r[gIdx]) :
    (gOff[1:0] == 2'h1) ? 32'(dly_r[gIdx]) :
    (gOff[1:0] == 2'h2) ? 32'(dial_r[gIdx]) : 32'(mult_r[gIdx]);
  wire [31:0] statRd = {26'h0, src_r, pick_r, bkQ_r, trQ_r, stQ_r};
  wire [31:0] rdMux =
    (regAddr == `NOV_REG_CTRL) ? 32'(ctrl_r) :
    (regAddr == `NOV_REG_IST) ? 32'(ist_r) :
    (regAddr == `NOV_REG_IMSK) ? 32'(imsk_r) :
    (regAddr == `NOV_REG_STAT) ? statRd :
    (regAddr == `NOV_REG_RELDLY) ? 32'(relDly_r) :
    (regAddr == `NOV_REG_RATIO) ? 32'(ratio_r) :
    (regAddr == `NOV_REG_EXPT) ? 32'(expT) :
    (regAddr == `NOV_REG_REMAIN) ? 32'(remain) :
    (regAddr == `NOV_REG_MEAS) ? 32'(meas_r) :
    gHit ? grpRd : 32'h0000_0000;
  logic [31:0] rdata_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= regRd ? rdMux : '0;
    end
  end
  assign regRdata = rdata_r;
endmodule
`default_nettype wire

// ---- pkg/nov_params.svh ----
// Function
// - residual is one third of phase sum
// - full earth fault reads 100 percent nominal
// - fundamental magnitudes refreshed every 5 ms
// - static input select, four choices
// - aux channels only in residual mode
// - force status gated by global enable
// - select and force ignore setting groups
// - pick up when measured exceeds threshold
// - release below 97 percent of threshold
// - threshold in 0.01 percent, default 20
// - threshold and timing from active group
// - unselected falls back or reports none
// - report measured to threshold ratio
// - report time remaining to trip
// - report expected time, inverse recomputed
// - block sampled per tick, raises blocked
// - fixed delay 5 ms steps, default 40 ms
// - inverse time dial over ratio power minus one
`ifndef NOV_PARAMS_SVH
`define NOV_PARAMS_SVH
`define NOV_CLK_HZ 20000000
`define NOV_TICK_US 5000
`define NOV_STEP_MS 5
`define NOV_DIAL_STEP_MS 10
`define NOV_MAX_TIME_MS 1800000
`define NOV_HYST_PCT 97
`define NOV_PCT_SCALE 100
`define NOV_THIRD_MUL 16'h5555
`define NOV_THIRD_SH 16
`define NOV_Q 8
`define NOV_SAT24 24'hffffff
`define NOV_REG_CTRL 5'h00
`define NOV_REG_IST 5'h01
`define NOV_REG_IMSK 5'h02
`define NOV_REG_STAT 5'h03
`define NOV_REG_RELDLY 5'h04
`define NOV_REG_RATIO 5'h05
`define NOV_REG_EXPT 5'h06
`define NOV_REG_REMAIN 5'h07
`define NOV_REG_MEAS 5'h08
`define NOV_REG_GRP0 5'h09
`define NOV_GRP_STRIDE 5'h04
`define NOV_GF_THR 5'h00
`define NOV_GF_DLY 5'h01
`define NOV_GF_DIAL 5'h02
`define NOV_GF_MULT 5'h03
`define NOV_CTL_SEL 1:0
`define NOV_CTL_FORCE 3:2
`define NOV_CTL_AUXA 4
`define NOV_CTL_AUXB 5
`define NOV_CTL_LN 6
`define NOV_CTL_GRP 7
`define NOV_CTL_RELEN 8
`define NOV_CTL_W 9
`define NOV_CTL_RST 9'h140
`define NOV_EV_START 0
`define NOV_EV_TRIP 1
`define NOV_EV_BLK 2
`define NOV_EV_W 3
`define NOV_THR_RST 16'h07d0
`define NOV_DLY_RST 19'h00008
`define NOV_DIAL_RST 16'h0005
`define NOV_MULT_RST 16'h0064
`define NOV_RELDLY_RST 15'h000c
`endif

// ---- pkg/nov_pkg.sv ----
package nov_pkg;
  typedef enum logic [1:0] {NOV_SRC_NONE, NOV_SRC_CALC, NOV_SRC_AUXA, NOV_SRC_AUXB} nov_src_type;
  typedef enum logic [1:0] {NOV_FRC_NORMAL, NOV_FRC_START, NOV_FRC_TRIP, NOV_FRC_BLOCKED}
    nov_force_type;
  typedef enum logic [2:0] {NOV_SQ_IDLE, NOV_SQ_RDIV, NOV_SQ_POW, NOV_SQ_TDIV, NOV_SQ_EVAL}
    nov_seq_type;
endpackage

// ---- hdl/nov_divider.sv ----
`timescale 1ns/10ps
`default_nettype none
module nov_divider #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic startDiv,
  input wire logic [W-1:0] numIn,
  input wire logic [W-1:0] denIn,
  output logic doneOut,
  output logic [W-1:0] quoOut
);
  localparam int CW = $clog2(W + 1);
  logic [W:0] rem_r;
  logic [W-1:0] quo_r;
  logic [W-1:0] den_r;
  logic [CW-1:0] cnt_r;
  logic busy_r;
  logic done_r;
  wire [W:0] shRem = {rem_r[W-1:0], quo_r[W-1]};
  wire [W:0] diff = shRem - {1'b0, den_r};
  wire take = ~diff[W];
  // zero divisor yields all ones, which callers treat as saturation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_r <= '0;
      quo_r <= '0;
      den_r <= '0;
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (startDiv) begin
      rem_r <= '0;
      quo_r <= numIn;
      den_r <= denIn;
      cnt_r <= CW'(W);
      busy_r <= 1'b1;
      done_r <= 1'b0;
    end else if (busy_r) begin
      rem_r <= take ? diff : shRem;
      quo_r <= {quo_r[W-2:0], take};
      cnt_r <= cnt_r - 1'b1;
      busy_r <= (cnt_r != CW'(1));
      done_r <= (cnt_r == CW'(1));
    end else begin
      done_r <= 1'b0;
    end
  end
  assign doneOut = done_r;
  assign quoOut = quo_r;
endmodule
`default_nettype wire

// ---- verif/nov_stage_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "nov_params.svh"
module nov_stage_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic startOut,
  input wire logic tripOut,
  input wire logic blockedOut,
  input wire nov_pkg::nov_src_type measNow,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  rd_idle_zero_a:
    assert property (regRdata != 32'h0 |-> $past(regRd)) else $error("read data outside slot");
  unmapped_rd_a:
    assert property (regRd && regAddr == 5'h1f |=> regRdata == 32'h0)
      else $error("unmapped read not zero");
  reldly_rw_a:
    assert property (regWr && regAddr == `NOV_REG_RELDLY ##1 !regWr
      ##1 regRd && regAddr == `NOV_REG_RELDLY |=> regRdata == {17'h0, $past(regWdata[14:0], 3)})
      else $error("release delay readback wrong");
  stat_mirror_a:
    assert property (regRd && regAddr == `NOV_REG_STAT |=> {regRdata[5:4], regRdata[2:0]} ==
      {$past(measNow), $past(blockedOut), $past(tripOut), $past(startOut)})
      else $error("status register differs from outputs");
  start_blk_excl_a:
    assert property (!(startOut && blockedOut)) else $error("start and blocked together");
  start_hold_a:
    assert property ($changed(startOut) |=> $stable(startOut) [*8]) else $error("start moved off tick");
  trip_hold_a:
    assert property ($changed(tripOut) |=> $stable(tripOut) [*8]) else $error("trip moved off tick");
  meas_hold_a:
    assert property ($changed(measNow) |=> !$changed(measNow) [*6]) else $error("source moved off tick");
  irq_clear_a:
    assert property ($fell(irq) |-> $past(regWr)) else $error("irq fell without a write");
endmodule
`default_nettype wire

// ---- verif/nov_front_end.sv ----
`timescale 1ns/10ps
`default_nettype none
module nov_front_end (
  input wire logic signed [15:0] phaseLvl,
  input wire logic [15:0] auxLvlA,
  input wire logic [15:0] auxLvlB,
  input wire logic blockReq,
  output logic signed [15:0] phaseOneRe,
  output logic signed [15:0] phaseOneIm,
  output logic signed [15:0] phaseTwoRe,
  output logic signed [15:0] phaseTwoIm,
  output logic signed [15:0] phaseThreeRe,
  output logic signed [15:0] phaseThreeIm,
  output logic [15:0] auxResidualA,
  output logic [15:0] auxResidualB,
  output logic blockIn
);
  // unequal phases: sum is three times the level, imaginary parts cancel
  assign phaseOneRe = phaseLvl <<< 1;
  assign phaseOneIm = 16'sh0;
  assign phaseTwoRe = phaseLvl;
  assign phaseTwoIm = phaseLvl;
  assign phaseThreeRe = 16'sh0;
  assign phaseThreeIm = -phaseLvl;
  assign auxResidualA = auxLvlA;
  assign auxResidualB = auxLvlB;
  // blocking matrix passes the request as a level
  assign blockIn = blockReq;
endmodule
`default_nettype wire

// ---- verif/nov_stage_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "nov_params.svh"
module nov_stage_tb_top;
  localparam int TICK = 100;
  localparam int LIMIT = 40000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic signed [15:0] phaseLvl = 16'sh0;
  logic [15:0] auxLvlA = 16'h0;
  logic [15:0] auxLvlB = 16'h0;
  logic blockReq = 1'b0;
  logic forceGlobalEn = 1'b0;
  logic [4:0] regAddr = 5'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic startOut, tripOut, blockedOut, irq, blockIn;
  logic signed [15:0] phaseOneRe, phaseOneIm, phaseTwoRe, phaseTwoIm, phaseThreeRe, phaseThreeIm;
  logic [15:0] auxResidualA, auxResidualB;
  nov_pkg::nov_src_type measNow;
  logic [2:0] outs;
  logic [31:0] rdv;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int k;
  assign outs = {blockedOut, tripOut, startOut};
  always #25 clk = ~clk;
  nov_front_end u_nov_front_end (.phaseLvl, .auxLvlA, .auxLvlB, .blockReq, .phaseOneRe,
    .phaseOneIm, .phaseTwoRe, .phaseTwoIm, .phaseThreeRe, .phaseThreeIm, .auxResidualA,
    .auxResidualB, .blockIn);
  nov_stage #(.TICK_CYC(TICK), .NGRP(2)) u_nov_stage (.clk, .rst_n, .phaseOneRe, .phaseOneIm,
    .phaseTwoRe, .phaseTwoIm, .phaseThreeRe, .phaseThreeIm, .auxResidualA, .auxResidualB,
    .blockIn, .forceGlobalEn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .startOut,
    .tripOut, .blockedOut, .measNow, .irq);
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // a hang is cut short here and still gets the closing report
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input logic [31:0] lo, input logic [31:0] hi,
    input logic [31:0] g);
    n_compared++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      n_errors++;
      $display("wrong value %s expected %h to %h seen %h", nm, lo, hi, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    d = regRdata;
  endtask
  task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] e);
    rd(a, rdv);
    chk(nm, e, rdv);
  endtask
  // bounded wait, k keeps the cycle count for delay checks
  task automatic wait_out(input int i, input logic v);
    k = 0;
    while (outs[i] !== v && k < 4 * TICK) begin
      @(posedge clk);
      k++;
    end
    chkb("protection output", v, outs[i]);
  endtask
  task automatic ticks(input int n);
    repeat (n * TICK) @(posedge clk);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rdc("control", `NOV_REG_CTRL, 32'h140);
    rdc("mask", `NOV_REG_IMSK, 32'h0);
    rdc("release", `NOV_REG_RELDLY, 32'hc);
    rdc("threshold", `NOV_REG_GRP0, 32'h7d0);
    rdc("delay", 5'h0a, 32'h8);
    rdc("dial", 5'h0b, 32'h5);
    rdc("power", 5'h0c, 32'h64);
    rdc("threshold g1", 5'h0d, 32'h7d0);
    wr(5'h1f, 32'hffffffff);
    rdc("unmapped", 5'h1f, 32'h0);
    wr(`NOV_REG_MEAS, 32'hffff);
    rdc("meas read only", `NOV_REG_MEAS, 32'h0);
    wr(`NOV_REG_RELDLY, 32'h12345678);
    rdc("release rw", `NOV_REG_RELDLY, 32'h5678);
    $display("test registers done");
    wr(`NOV_REG_CTRL, 32'h52);
    wr(5'h0a, 32'h2);
    wr(`NOV_REG_IMSK, 32'h7);
    @(posedge clk) auxLvlA <= 16'h0bb8;
    wait_out(0, 1'b1);
    chkb("trip at start", 1'b0, tripOut);
    chk("source", 32'h2, 32'(measNow));
    rdc("remaining", `NOV_REG_REMAIN, 32'h2);
    wait_out(1, 1'b1);
    chk_rng("trip delay", 32'd150, 32'd250, 32'(k));
    rdc("meas", `NOV_REG_MEAS, 32'hbb8);
    rdc("ratio", `NOV_REG_RATIO, 32'h96);
    rdc("expected", `NOV_REG_EXPT, 32'h2);
    rdc("status", `NOV_REG_STAT, 32'h2b);
    chkb("irq", 1'b1, irq);
    rdc("events", `NOV_REG_IST, 32'h3);
    wr(`NOV_REG_IMSK, 32'h0);
    rdc("mask off", `NOV_REG_IMSK, 32'h0);
    chkb("irq masked", 1'b0, irq);
    wr(`NOV_REG_IMSK, 32'h7);
    wr(`NOV_REG_IST, 32'h7);
    rdc("events clear", `NOV_REG_IST, 32'h0);
    chkb("irq cleared", 1'b0, irq);
    @(posedge clk) auxLvlA <= 16'h079e;
    ticks(3);
    chkb("held in band", 1'b1, startOut);
    @(posedge clk) auxLvlA <= 16'h078a;
    wait_out(0, 1'b0);
    rdc("remaining idle", `NOV_REG_REMAIN, 32'h0);
    @(posedge clk) auxLvlA <= 16'h07d0;
    ticks(3);
    chkb("at threshold", 1'b0, startOut);
    $display("test pickup done");
    @(posedge clk) auxLvlA <= 16'h0bb8;
    wait_out(0, 1'b1);
    @(posedge clk) blockReq <= 1'b1;
    wait_out(0, 1'b0);
    @(posedge clk) auxLvlA <= 16'h0;
    ticks(2);
    @(posedge clk) auxLvlA <= 16'h0bb8;
    wait_out(2, 1'b1);
    chkb("no start", 1'b0, startOut);
    rdc("blocked event", `NOV_REG_IST, 32'h5);
    @(posedge clk) auxLvlA <= 16'h0;
    blockReq <= 1'b0;
    wait_out(2, 1'b0);
    $display("test blocking done");
    wr(5'h0d, 32'hfa0);
    wr(5'h0e, 32'h0);
    wr(`NOV_REG_CTRL, 32'hd2);
    @(posedge clk) auxLvlA <= 16'h0bb8;
    ticks(3);
    chkb("group threshold", 1'b0, startOut);
    chk("source kept", 32'h2, 32'(measNow));
    @(posedge clk) auxLvlA <= 16'h1388;
    wait_out(0, 1'b1);
    chkb("instant trip", 1'b1, tripOut);
    @(posedge clk) auxLvlA <= 16'h0;
    wait_out(0, 1'b0);
    $display("test groups done");
    wr(`NOV_REG_CTRL, 32'h40);
    @(posedge clk) phaseLvl <= 16'sh2710;
    wait_out(0, 1'b1);
    chk("source calc", 32'h1, 32'(measNow));
    rd(`NOV_REG_MEAS, rdv);
    chk_rng("calc", 32'h270e, 32'h2710, rdv);
    wr(`NOV_REG_CTRL, 32'h0);
    ticks(3);
    chk("no source", 32'h0, 32'(measNow));
    chkb("no pickup", 1'b0, startOut);
    wr(`NOV_REG_CTRL, 32'h2);
    @(posedge clk) auxLvlA <= 16'h0bb8;
    ticks(3);
    chkb("aux not residual", 1'b0, startOut);
    wr(`NOV_REG_CTRL, 32'h23);
    @(posedge clk) auxLvlB <= 16'h0bb8;
    wait_out(0, 1'b1);
    chk("source aux b", 32'h3, 32'(measNow));
    @(posedge clk) auxLvlB <= 16'h0;
    auxLvlA <= 16'h0;
    phaseLvl <= 16'sh0;
    wait_out(0, 1'b0);
    $display("test sources done");
    wr(`NOV_REG_CTRL, 32'h56);
    ticks(3);
    chkb("force gated", 1'b0, startOut);
    @(posedge clk) forceGlobalEn <= 1'b1;
    for (int f = 1; f < 4; f++) begin
      wr(`NOV_REG_CTRL, 32'h50 | 32'(f << 2));
      wait_out(f - 1, 1'b1);
      // forced levels must stand past the hold window of the monitor
      ticks(1);
    end
    wr(`NOV_REG_CTRL, 32'h50);
    wait_out(2, 1'b0);
    $display("test forcing done");
    report_and_stop();
  end
endmodule
bind nov_stage nov_stage_monitor u_nov_stage_monitor (.clk(clk), .rst_n(rst_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .startOut(startOut), .tripOut(tripOut), .blockedOut(blockedOut), .measNow(measNow),
  .irq(irq));
`default_nettype wire
